// ---- hw/hpio_top.sv ----
// handler parallel io port: output, bidirectional and status lines
// Function
// - two 8-bit outputs, two 4-bit bidirectional ports
// - ports combine to 16-bit out, 8-bit in
// - data lines active low, polarity invertible
// - low pulse asserts both latched flags
// - latched flag polarity selectable by software
// - first port eight dedicated active-low outputs
// - second port eight outputs, top bits shareable
// - measurement complete low after all sweeps
// - handler waits for calculation before reading data
// - point trigger: complete high first, low last
// - ready-for-trigger low when trigger acceptable
// - ready-for-trigger high on first trigger
// - ready returns low per point or sweep
// - select b6 data or measurement complete
// - select b7 data or ready for trigger
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module hpio_top
	import hpio_pkg::*;
(
	input wire logic CLK_IN,
	input wire logic RSTN_IN,
	input wire logic [3:0] ADDR_IN,
	input wire logic [15:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [15:0] RDATA_OUT,
	input wire logic FLAG_SET_PULSE_IN,
	output logic LATCHED_FLAG_FIRST_OUT,
	output logic LATCHED_FLAG_SECOND_OUT,
	output logic [7:0] PORT_A_OUT,
	output logic [7:0] PORT_B_OUT,
	input wire logic [3:0] PORT_C_IN,
	output logic [3:0] PORT_C_OUT,
	output logic [3:0] PORT_C_OEN_OUT,
	input wire logic [3:0] PORT_D_IN,
	output logic [3:0] PORT_D_OUT,
	output logic [3:0] PORT_D_OEN_OUT,
	output logic PORT_C_STATUS_OUT,
	output logic PORT_D_STATUS_OUT
);
	import hpio_pkg::*;
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [7:0] port_a_r; // logical data, port a
	logic [7:0] port_b_r; // logical data, port b
	logic [3:0] port_c_r; // logical data, port c
	logic [3:0] port_d_r; // logical data, port d
	logic [7:0] ctrl_r; // configuration
	logic flag_r; // latched flag asserted
	logic complete_r; // measurement complete asserted
	logic ready_r; // ready for trigger asserted
	logic [3:0] c_meta_r, c_sync_r; // port c input synchroniser
	logic [3:0] d_meta_r, d_sync_r; // port d input synchroniser
	logic flag_fall; // one cycle per handler pulse
	logic [7:0] pol; // xor mask for data lines
	logic wr_ctrl, wr_meas; // decoded writes
	assign pol = ctrl_r[CTRL_DATA_POS] ? 8'h00 : 8'hff;
	assign wr_ctrl = WR_IN && (ADDR_IN == ADDR_CTRL);
	assign wr_meas = WR_IN && (ADDR_IN == ADDR_MEAS);
	// ---------------------------------------------------------------
	// pulse input edge detection
	// ---------------------------------------------------------------
	hpio_edge_sync u_sync (
		.clk_in(CLK_IN),
		.rstn_in(RSTN_IN),
		.async_in(FLAG_SET_PULSE_IN),
		.fall_out(flag_fall)
	);
	// ---------------------------------------------------------------
	// configuration register
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			ctrl_r <= CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_r <= {1'b0, WDATA_IN[6:0]}; // clear bit is self clearing
		end
	end
	// ---------------------------------------------------------------
	// port data registers, single and combined views
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			port_a_r <= DATA_RST;
			port_b_r <= DATA_RST;
			port_c_r <= DATA_RST[3:0];
			port_d_r <= DATA_RST[3:0];
		end else if (WR_IN) begin
			case (ADDR_IN)
				ADDR_PORT_A: port_a_r <= WDATA_IN[7:0];
				ADDR_PORT_B: port_b_r <= WDATA_IN[7:0];
				ADDR_PORT_C: port_c_r <= WDATA_IN[3:0];
				ADDR_PORT_D: port_d_r <= WDATA_IN[3:0];
				ADDR_PORT_E: begin
					port_c_r <= WDATA_IN[3:0];
					port_d_r <= WDATA_IN[7:4];
				end
				ADDR_PORT_F: begin
					port_a_r <= WDATA_IN[7:0];
					port_b_r <= WDATA_IN[15:8];
				end
				default: ;
			endcase
		end
	end
	// ---------------------------------------------------------------
	// latched flags: set by handler pulse, set wins over clear
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			flag_r <= 1'b0;
		end else if (flag_fall) begin
			flag_r <= 1'b1;
		end else if (wr_ctrl && WDATA_IN[CTRL_FLAG_CLR]) begin
			flag_r <= 1'b0;
		end
	end
	// ---------------------------------------------------------------
	// measurement status tracking
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			complete_r <= 1'b0;
		end else if (wr_meas && WDATA_IN[MEAS_SWEEP]) begin
			complete_r <= 1'b1;
		end else if (wr_meas && WDATA_IN[MEAS_TRIG] && !complete_r) begin
			complete_r <= complete_r; // mid sweep, hold
		end else if (wr_meas && WDATA_IN[MEAS_ARM]) begin
			complete_r <= 1'b0; // new sweep starting
		end
	end
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			ready_r <= 1'b0;
		end else if (wr_meas && WDATA_IN[MEAS_TRIG]) begin
			ready_r <= 1'b0;
		end else if (wr_meas && WDATA_IN[MEAS_SWEEP]) begin
			ready_r <= 1'b1;
		end else if (wr_meas && WDATA_IN[MEAS_POINT] && ctrl_r[CTRL_PT_TRIG]) begin
			ready_r <= 1'b1;
		end else if (wr_meas && WDATA_IN[MEAS_ARM]) begin
			ready_r <= 1'b1;
		end
	end
	// ---------------------------------------------------------------
	// input synchronisers for bidirectional ports
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			c_meta_r <= 4'hf;
			c_sync_r <= 4'hf;
			d_meta_r <= 4'hf;
			d_sync_r <= 4'hf;
		end else begin
			c_meta_r <= PORT_C_IN;
			c_sync_r <= c_meta_r;
			d_meta_r <= PORT_D_IN;
			d_sync_r <= d_meta_r;
		end
	end
	// ---------------------------------------------------------------
	// pin drivers, all registered
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			PORT_A_OUT <= 8'hff;
			PORT_B_OUT <= 8'hff;
			PORT_C_OUT <= 4'hf;
			PORT_D_OUT <= 4'hf;
			PORT_C_OEN_OUT <= 4'hf;
			PORT_D_OEN_OUT <= 4'hf;
			PORT_C_STATUS_OUT <= 1'b0;
			PORT_D_STATUS_OUT <= 1'b0;
			LATCHED_FLAG_FIRST_OUT <= 1'b1;
			LATCHED_FLAG_SECOND_OUT <= 1'b1;
		end else begin
			PORT_A_OUT <= port_a_r ^ pol;
			PORT_B_OUT[5:0] <= port_b_r[5:0] ^ pol[5:0];
			PORT_B_OUT[6] <= ctrl_r[CTRL_IDX_SEL] ? ~complete_r
				: (port_b_r[6] ^ pol[6]);
			PORT_B_OUT[7] <= ctrl_r[CTRL_RTR_SEL] ? ~ready_r
				: (port_b_r[7] ^ pol[7]);
			PORT_C_OUT <= port_c_r ^ pol[3:0];
			PORT_D_OUT <= port_d_r ^ pol[3:0];
			PORT_C_OEN_OUT <= {4{~ctrl_r[CTRL_DIR_C]}}; // low while driving
			PORT_D_OEN_OUT <= {4{~ctrl_r[CTRL_DIR_D]}};
			PORT_C_STATUS_OUT <= ctrl_r[CTRL_DIR_C];
			PORT_D_STATUS_OUT <= ctrl_r[CTRL_DIR_D];
			LATCHED_FLAG_FIRST_OUT <= flag_r ^ ~ctrl_r[CTRL_FLAG_POS];
			LATCHED_FLAG_SECOND_OUT <= flag_r ^ ~ctrl_r[CTRL_FLAG_POS];
		end
	end
	// ---------------------------------------------------------------
	// read data, one cycle after strobe
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			RDATA_OUT <= 16'h0000;
		end else if (RD_IN) begin
			case (ADDR_IN)
				ADDR_PORT_A: RDATA_OUT <= {8'h00, port_a_r};
				ADDR_PORT_B: RDATA_OUT <= {8'h00, port_b_r};
				ADDR_PORT_C: RDATA_OUT <= {12'h000, ctrl_r[CTRL_DIR_C] ? port_c_r
					: (c_sync_r ^ pol[3:0])};
				ADDR_PORT_D: RDATA_OUT <= {12'h000, ctrl_r[CTRL_DIR_D] ? port_d_r
					: (d_sync_r ^ pol[3:0])};
				ADDR_PORT_E: RDATA_OUT <= {8'h00, d_sync_r ^ pol[3:0],
					c_sync_r ^ pol[3:0]};
				ADDR_PORT_F: RDATA_OUT <= {port_b_r, port_a_r};
				ADDR_CTRL: RDATA_OUT <= {8'h00, ctrl_r};
				ADDR_STAT: RDATA_OUT <= {13'h0, ready_r, complete_r, flag_r};
				default: RDATA_OUT <= 16'h0000;
			endcase
		end else begin
			RDATA_OUT <= 16'h0000;
		end
	end
	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	// trigger without a sweep end in the same write
	sequence s_trig;
		wr_meas && WDATA_IN[MEAS_TRIG] && !WDATA_IN[MEAS_SWEEP];
	endsequence
	// sweep end without a trigger in the same write
	sequence s_sweep;
		wr_meas && WDATA_IN[MEAS_SWEEP] && !WDATA_IN[MEAS_TRIG];
	endsequence
	// armed report on its own
	sequence s_arm;
		wr_meas && WDATA_IN == 16'(1 << MEAS_ARM);
	endsequence
	// point end on its own
	sequence s_point;
		wr_meas && WDATA_IN == 16'(1 << MEAS_POINT);
	endsequence
	// flag pin shows the asserted level two edges after the pulse edge
	a_flag_set: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
		flag_fall |=> ##1 (LATCHED_FLAG_FIRST_OUT == $past(ctrl_r[CTRL_FLAG_POS])))
		else $error("flag not asserted after pulse");
	// a pulse beats a clear written in the same cycle
	a_flag_wins: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
		flag_fall |=> flag_r)
		else $error("flag lost against clear");
	// a clear with no pulse pending drops the flag
	a_flag_clear: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
		wr_ctrl && WDATA_IN[CTRL_FLAG_CLR] && !flag_fall |=> !flag_r)
		else $error("flag not cleared");
	// both latched flag pins always agree
	a_flag_pair: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
		LATCHED_FLAG_FIRST_OUT == LATCHED_FLAG_SECOND_OUT)
		else $error("latched flags differ");
	// active-low data lines by default
	a_port_a_pol: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
		WR_IN && ADDR_IN == ADDR_PORT_A && !ctrl_r[CTRL_DATA_POS] && !wr_ctrl
		|=> ##1 PORT_A_OUT == ~$past(WDATA_IN[7:0], 2))
		else $error("port a not active low");
	// sixteen-bit write lands on port a and on b0 to b5 of port b
	a_port_f_wide: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
		WR_IN && ADDR_IN == ADDR_PORT_F
		|=> ##1 {PORT_B_OUT[5:0], PORT_A_OUT} == $past(WDATA_IN[13:0] ^ {pol[5:0], pol}, 2))
		else $error("combined port write not on pins");
	// trigger takes ready away
	a_ready_trig: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
		s_trig |=> !ready_r)
		else $error("ready stays asserted after trigger");
	// point end brings ready back under point triggering
	a_ready_point: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
		s_point and ctrl_r[CTRL_PT_TRIG] |=> ready_r)
		else $error("ready not back after point");
	// without point triggering a point end leaves ready alone
	a_ready_hold: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
		s_point and !ctrl_r[CTRL_PT_TRIG] |=> ready_r == $past(ready_r))
		else $error("ready moved on point without point trigger");
	// sweep end brings ready back
	a_ready_sweep: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
		s_sweep |=> ready_r)
		else $error("ready not back after sweep");
	// armed sequencer shows ready
	a_ready_arm: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
		s_arm |=> ready_r)
		else $error("ready not shown when armed");
	// sweep end raises complete
	a_complete_sw: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
		wr_meas && WDATA_IN[MEAS_SWEEP] |=> complete_r)
		else $error("complete not set at sweep end");
	// a new sweep clears complete
	a_complete_arm: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
		s_arm |=> !complete_r)
		else $error("complete not cleared for new sweep");
	// shared lines carry status when selected
	a_index_pin: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
		ctrl_r[CTRL_IDX_SEL] && !wr_ctrl |=> PORT_B_OUT[6] == ~$past(complete_r))
		else $error("b6 not carrying complete");
	a_rtr_pin: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
		ctrl_r[CTRL_RTR_SEL] && !wr_ctrl |=> PORT_B_OUT[7] == ~$past(ready_r))
		else $error("b7 not carrying ready");
	// output enables follow the direction bits
	a_dir_c: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
		1'b1 |=> PORT_C_OEN_OUT == {4{~$past(ctrl_r[CTRL_DIR_C])}})
		else $error("port c enable wrong");
	a_dir_d: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
		1'b1 |=> PORT_D_OEN_OUT == {4{~$past(ctrl_r[CTRL_DIR_D])}})
		else $error("port d enable wrong");
endmodule : hpio_top

// ---- hw/hpio_pkg.sv ----
// package of constants for the handler parallel io port
package hpio_pkg;
	// ---------------------------------------------------------------
	// register map (word index equals byte address, plain port)
	// ---------------------------------------------------------------
	localparam logic [3:0] ADDR_PORT_A = 4'h0; // first output port data
	localparam logic [3:0] ADDR_PORT_B = 4'h1; // second output port data
	localparam logic [3:0] ADDR_PORT_C = 4'h2; // first 4-bit port data
	localparam logic [3:0] ADDR_PORT_D = 4'h3; // second 4-bit port data
	localparam logic [3:0] ADDR_PORT_E = 4'h4; // combined 8-bit port (c low, d high)
	localparam logic [3:0] ADDR_PORT_F = 4'h5; // combined 16-bit output (a low, b high)
	localparam logic [3:0] ADDR_CTRL = 4'h6; // configuration bits
	localparam logic [3:0] ADDR_STAT = 4'h7; // status bits
	localparam logic [3:0] ADDR_MEAS = 4'h8; // measurement event strobes (write only)
	// ---------------------------------------------------------------
	// control register fields
	// ---------------------------------------------------------------
	localparam int CTRL_DIR_C = 0; // 1: port c drives
	localparam int CTRL_DIR_D = 1; // 1: port d drives
	localparam int CTRL_DATA_POS = 2; // 1: data lines active high
	localparam int CTRL_FLAG_POS = 3; // 1: latched flags asserted high
	localparam int CTRL_IDX_SEL = 4; // 1: b6 line carries measurement complete
	localparam int CTRL_RTR_SEL = 5; // 1: b7 line carries ready for trigger
	localparam int CTRL_PT_TRIG = 6; // 1: per point triggering
	localparam int CTRL_FLAG_CLR = 7; // write 1: deassert latched flags
	localparam logic [7:0] CTRL_RST = 8'h00; // reset value of control
	// ---------------------------------------------------------------
	// measurement strobe fields (from the instrument sequencer)
	// ---------------------------------------------------------------
	localparam int MEAS_TRIG = 0; // trigger accepted
	localparam int MEAS_POINT = 1; // a point finished
	localparam int MEAS_SWEEP = 2; // the whole sweep finished
	localparam int MEAS_ARM = 3; // ready to accept a trigger
	localparam logic [7:0] DATA_RST = 8'h00; // reset value of port data
endpackage : hpio_pkg

// ---- hw/hpio_edge_sync.sv ----
// two flop synchroniser with falling edge detector
`timescale 1ns/10ps
module hpio_edge_sync (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic async_in,
	output logic fall_out
);
	logic meta_r; // first stage, read only by sync_r
	logic sync_r; // second stage
	logic prev_r; // delayed copy for edge detection
	// ---------------------------------------------------------------
	// synchroniser chain
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
			prev_r <= 1'b1;
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end
	// one pulse per low-going edge
	assign fall_out = prev_r & ~sync_r;
	a_fall_once: assert property (@(posedge clk_in) disable iff (!rstn_in)
		fall_out |=> !fall_out) else $error("falling edge pulse longer than one cycle");
endmodule : hpio_edge_sync

// ---- sim/hpio_handler_model.sv ----
// behavioural model of the component handler on the far side
`timescale 1ns/10ps
module hpio_handler_model (
	input wire logic clk_in,
	output logic pulse_n_out,
	output logic [3:0] c_drv_out,
	output logic [3:0] d_drv_out,
	output logic [1:0] drv_en_out
);
	// ---------------------------------------------------------------
	// idle state: pulse line high, lines released
	// ---------------------------------------------------------------
	initial begin
		pulse_n_out = 1'b1;
		c_drv_out = 4'h0;
		d_drv_out = 4'h0;
		drv_en_out = 2'b00;
	end
	// low pulse, never shorter than two device cycles
	task automatic pulse(input int len);
		pulse_n_out <= 1'b0;
		repeat ((len < 2) ? 2 : len) @(posedge clk_in);
		pulse_n_out <= 1'b1;
	endtask : pulse
	// put values on the c and d lines; en bit 0 for c, bit 1 for d
	task automatic drive(input logic [3:0] c, input logic [3:0] d, input logic [1:0] en);
		c_drv_out <= c;
		d_drv_out <= d;
		drv_en_out <= en;
	endtask : drive
endmodule : hpio_handler_model

// ---- sim/tb_handler_parallel_io_port.sv ----
// self-checking testbench for the handler parallel io port
`timescale 1ns/10ps
`define CHK(act, exp) begin n_compared++; if ((act) !== (exp)) begin n_errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, act, exp); end end
module tb_handler_parallel_io_port;
	import hpio_pkg::*;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic clk, rstn, wr, rd, pulse_n, fl1, fl2, c_st, d_st;
	logic [1:0] h_en; // handler drive enables
	logic [3:0] addr, c_oen, d_oen, c_out, d_out, h_c, h_d, c_wire, d_wire, c_d, d_d;
	logic [15:0] wdata, rdata;
	logic [7:0] pa, pb, ctrl, a_d, b_d; // ctrl and *_d: shadow of written values
	int n_errors = 0;
	int n_compared = 0;
	int seed = 32'h7d89;
	// released lines float high through the pull-ups
	assign c_wire = (~c_oen & c_out) | (c_oen & (h_en[0] ? h_c : 4'hf));
	assign d_wire = (~d_oen & d_out) | (d_oen & (h_en[1] ? h_d : 4'hf));
	hpio_top uut (.CLK_IN(clk), .RSTN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
		.RD_IN(rd), .RDATA_OUT(rdata), .FLAG_SET_PULSE_IN(pulse_n),
		.LATCHED_FLAG_FIRST_OUT(fl1), .LATCHED_FLAG_SECOND_OUT(fl2), .PORT_A_OUT(pa),
		.PORT_B_OUT(pb), .PORT_C_IN(c_wire), .PORT_C_OUT(c_out), .PORT_C_OEN_OUT(c_oen),
		.PORT_D_IN(d_wire), .PORT_D_OUT(d_out), .PORT_D_OEN_OUT(d_oen),
		.PORT_C_STATUS_OUT(c_st), .PORT_D_STATUS_OUT(d_st));
	hpio_handler_model hdl (.clk_in(clk), .pulse_n_out(pulse_n), .c_drv_out(h_c),
		.d_drv_out(h_d), .drv_en_out(h_en));
	// 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [7:0] pin8(input logic [7:0] v, input logic pos);
		return pos ? v : ~v;
	endfunction : pin8
	task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
		@(posedge clk);
	endtask : bus
	task automatic idle(input int n);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (n) @(posedge clk);
	endtask : idle
	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask : wreg
	task automatic cw(input logic [7:0] v);
		ctrl = v & 8'h7f; // clear bit reads back 0
		wreg(ADDR_CTRL, {8'h00, v});
	endtask : cw
	// read data stand in the cycle after the strobe
	task automatic rchk(input logic [3:0] a, input logic [15:0] e);
		bus(1'b0, 1'b1, a, 16'h0000);
		idle(1);
		`CHK(rdata, e)
	endtask : rchk
	// compare the data pins with the shadow values, skipping status-carrying b6/b7 and undriven c/d
	task automatic pins();
		logic [7:0] eb;
		idle(3);
		eb = pin8(b_d, ctrl[CTRL_DATA_POS]);
		`CHK(pa, pin8(a_d, ctrl[CTRL_DATA_POS]))
		`CHK(pb[5:0], eb[5:0])
		if (!ctrl[CTRL_IDX_SEL]) `CHK(pb[6], eb[6])
		if (!ctrl[CTRL_RTR_SEL]) `CHK(pb[7], eb[7])
		`CHK({c_st, d_st}, {ctrl[CTRL_DIR_C], ctrl[CTRL_DIR_D]})
		`CHK({c_oen, d_oen}, {{4{~ctrl[CTRL_DIR_C]}}, {4{~ctrl[CTRL_DIR_D]}}})
		if (ctrl[CTRL_DIR_C]) `CHK(c_out, 4'(pin8({4'h0, c_d}, ctrl[CTRL_DATA_POS])))
		if (ctrl[CTRL_DIR_D]) `CHK(d_out, 4'(pin8({4'h0, d_d}, ctrl[CTRL_DATA_POS])))
	endtask : pins
	// one sequencer event, then the shared b7/b6 lines
	task automatic meas(input int n, input logic rdy, input logic cmp);
		wreg(ADDR_MEAS, 16'(1 << n));
		idle(3);
		`CHK({pb[7], pb[6]}, {rdy, cmp})
	endtask : meas
	task automatic test_done();
		if (n_errors == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : test_done
	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		test_done();
	end
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [3:0] hc, hd;
		rstn = 1'b0;
		{wr, rd, addr, wdata} = '0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		idle(1);
		`CHK({pa, pb}, 16'hffff)
		`CHK({c_oen, d_oen, c_st, d_st, fl1, fl2}, 12'hff3)
		rchk(ADDR_CTRL, {8'h00, CTRL_RST});
		rchk(4'hf, 16'h0000);
		// random data, directions and polarity
		for (int i = 0; i < 12; i++) begin
			cw(8'($random(seed)) & 8'h4f);
			{a_d, b_d, c_d, d_d} = 24'($random(seed));
			{hc, hd} = 8'($random(seed));
			if (i[0]) wreg(ADDR_PORT_F, {b_d, a_d});
			else begin
				wreg(ADDR_PORT_A, {8'h00, a_d});
				wreg(ADDR_PORT_B, {8'h00, b_d});
			end
			if (i[1]) wreg(ADDR_PORT_E, {8'h00, d_d, c_d});
			else begin
				wreg(ADDR_PORT_C, {12'h000, c_d});
				wreg(ADDR_PORT_D, {12'h000, d_d});
			end
			wreg(4'h9, 16'hffff); // unmapped, ignored
			hdl.drive(hc, hd, {~ctrl[CTRL_DIR_D], ~ctrl[CTRL_DIR_C]});
			pins();
			rchk(ADDR_PORT_A, {8'h00, a_d});
			rchk(ADDR_PORT_B, {8'h00, b_d});
			rchk(ADDR_PORT_F, {b_d, a_d});
			if (!ctrl[CTRL_DIR_C]) rchk(ADDR_PORT_C, {12'h000, 4'(pin8({4'h0, hc}, ctrl[2]))});
			if (!ctrl[CTRL_DIR_D]) rchk(ADDR_PORT_D, {12'h000, 4'(pin8({4'h0, hd}, ctrl[2]))});
			if (ctrl[1:0] == 2'b00) rchk(ADDR_PORT_E, {8'h00, pin8({hd, hc}, ctrl[2])});
		end
		// status on shared lines, with and without point triggering
		for (int pt = 0; pt < 2; pt++) begin
			cw(8'h34 | 8'(pt << 6));
			meas(MEAS_ARM, 1'b0, 1'b1);
			meas(MEAS_TRIG, 1'b1, 1'b1);
			meas(MEAS_POINT, (pt == 0), 1'b1);
			meas(MEAS_SWEEP, 1'b0, 1'b0);
			rchk(ADDR_STAT, 16'h0006);
			meas(MEAS_ARM, 1'b0, 1'b1);
		end
		// latched flags, both polarities
		for (int p = 0; p < 2; p++) begin
			cw(8'h80 | 8'(p << 3));
			idle(1);
			hdl.pulse(2);
			idle(4);
			`CHK({fl1, fl2}, {2{p[0]}})
			rchk(ADDR_STAT, 16'h0005);
			fork
				hdl.pulse(12);
			join_none
			idle(6);
			cw(8'h80 | 8'(p << 3));
			idle(10);
			`CHK({fl1, fl2}, {2{~p[0]}})
		end
		test_done();
	end
endmodule : tb_handler_parallel_io_port
